// ### include/fss_pkg.sv
/*
 Shared constants and carrier types of the fieldbus scan scheduler.
 Assumes a single clock domain; no other dependency.
*/
`default_nettype none
package fss_pkg;
   // Network and data table geometry
   localparam int NUM_DEV = 64;
   localparam int NODE_W = 6;
   localparam int NUM_BLK = 32;
   localparam int BLK_BYTES = 128;
   localparam int BLK_WORDS = BLK_BYTES / 2;
   localparam int BT_BLKS = 8;
   localparam int BT_WORDS = 60;
   localparam int HD_IN_BLK = 31;
   localparam int HD_OUT_BLK = 32;
   localparam int HD_POINTS = 32;
   localparam int BT_MEM_WORDS = BT_BLKS * BLK_WORDS;
   // Point selectors inside an image: words, then discrete halves
   localparam logic [5:0] SEL_DISC_LO = 6'h20;
   localparam logic [5:0] SEL_DISC_HI = 6'h21;
   // Scan timing
   localparam int INTV_W = 24;
   localparam int RETRY_W = 3;
   localparam logic [7:0] TMO_MULT = 8'h04;
   // Link bit rate codes
   localparam logic [1:0] RATE_125K = 2'h0;
   localparam logic [1:0] RATE_250K = 2'h1;
   localparam logic [1:0] RATE_500K = 2'h2;

   typedef enum logic [1:0] {MSG_STROBE, MSG_POLL, MSG_IDREQ, MSG_IO} fss_msg_kind_t;
   typedef enum logic [2:0] {S_OFF, S_WAIT, S_STROBE, S_SEND, S_MAP, S_COMMIT} fss_state_t;

   typedef struct packed {
      logic active;
      logic strobe;
      logic poll;
      logic cyclic;
      logic [3:0] rate;
      logic [7:0] cyc_scans;
      logic [5:0] map_sel;
      logic [15:0] ident;
   } fss_dev_cfg_t;

   typedef struct packed {
      logic [HD_POINTS-1:0] disc;
      logic [HD_POINTS-1:0][15:0] words;
   } fss_img_t;

   typedef struct packed {
      fss_msg_kind_t kind;
      logic [NODE_W-1:0] node;
      logic [15:0] data;
   } fss_msg_t;

   typedef struct packed {
      logic write;
      logic [2:0] blk;
      logic [5:0] word;
      logic [15:0] wdata;
   } fss_bt_req_t;
endpackage
`default_nettype wire

// ### rtl/fss_dev_tracker.sv
/*
 Per-device connection, poll rate, timeout and response buffer.
 Assumes scan_start and the response strobes are one-cycle pulses.
*/
`timescale 1ns/10ps
`default_nettype none
module fss_dev_tracker (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Configuration
   input wire fss_pkg::fss_dev_cfg_t cfg,
   // Scan events
   input wire logic scan_start,
   input wire logic id_rsp,
   input wire logic io_rsp,
   input wire logic [15:0] rsp_data,
   input wire logic map_ack,
   // State
   output logic poll_due_ff,
   output logic conn_ff,
   output logic err_ff,
   output logic pend_ff,
   output logic [15:0] data_ff
);
   logic [3:0] div_ff;
   logic [7:0] miss_ff;
   logic [3:0] last_rate;
   logic [7:0] limit;

   assign last_rate = (cfg.rate == 4'h0) ? 4'h0 : cfg.rate - 4'h1;
   // Non-cyclic timeout never shorter than the poll period, so a slow device gets its N scans
   assign limit = cfg.cyclic ? cfg.cyc_scans : 8'({4'h0, last_rate} + 8'h01) * fss_pkg::TMO_MULT; // RULE_17

   always_ff @(posedge clock) begin
      if (rst) begin
         div_ff <= 4'h0;
         poll_due_ff <= 1'b0;
      end else if (scan_start) begin
         poll_due_ff <= (div_ff == 4'h0); // RULE_16
         div_ff <= (div_ff >= last_rate) ? 4'h0 : div_ff + 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         conn_ff <= 1'b0;
         err_ff <= 1'b0;
         miss_ff <= 8'h00;
      end else if (id_rsp) begin
         conn_ff <= (rsp_data == cfg.ident); // RULE_10
         err_ff <= (rsp_data != cfg.ident);
         miss_ff <= 8'h00;
      end else if (conn_ff && io_rsp) begin
         miss_ff <= 8'h00;
      end else if (conn_ff && scan_start) begin
         if (miss_ff >= limit) begin
            conn_ff <= 1'b0; // RULE_17
            err_ff <= 1'b1;
         end
         miss_ff <= miss_ff + 8'h01;
      end
   end

   // Response buffer: a new arrival beats the clear from the mapper
   always_ff @(posedge clock) begin
      if (rst) begin
         pend_ff <= 1'b0;
         data_ff <= 16'h0000;
      end else if (conn_ff && io_rsp) begin
         pend_ff <= 1'b1; // RULE_12
         data_ff <= rsp_data;
      end else if (map_ack) begin
         pend_ff <= 1'b0;
      end
   end
endmodule // fss_dev_tracker
`default_nettype wire

// ### rtl/fss_low_pick.sv
/*
 Lowest-index request picker.
 Assumes purely combinational use by the scan scheduler.
*/
`timescale 1ns/10ps
`default_nettype none
module fss_low_pick #(
   parameter int W = 64,
   parameter int IW = 6
) (
   // Requests
   input wire logic [W-1:0] req,
   // Result
   output logic any,
   output logic [IW-1:0] idx
);
   always_comb begin
      any = 1'b0;
      idx = '0;
      for (int i = W - 1; i >= 0; i--) begin
         if (req[i]) begin
            any = 1'b1;
            idx = IW'(i);
         end
      end
   end
endmodule // fss_low_pick
`default_nettype wire

// ### rtl/fss_scan_scheduler.sv
/*
 Fieldbus scan scheduler: data table, host fast image, block transfer
 port and the fixed-interval network scan with per-device tracking.
 Assumes a framing controller outside that sends tx_msg_ff on a
 valid/ready handshake and delivers decoded frames as rx pulses.
*/
// Notes on behaviour
// RULE_01: Table is thirty-two blocks of 128 bytes.
// RULE_02: First eight blocks serve block transfers.
// RULE_03: Host fast inputs come from block 31.
// RULE_04: Host fast outputs land in block 32.
// RULE_05: A block reaches the host all at once.
// RULE_06: Fast image exchanged every host scan.
// RULE_07: Block transfer: eight blocks, sixty words each.
// RULE_08: Network scan independent; host reads newest inputs.
// RULE_09: Scanner reads last host-written outputs.
// RULE_10: Identity must match before I/O starts.
// RULE_11: Scans start at fixed start-to-start interval.
// RULE_12: Scan sends all messages; responses are buffered.
// RULE_13: Map responses only after all sends.
// RULE_14: Finished early means idle until interval.
// RULE_15: Late scan extends and flags overrun.
// RULE_16: Device polled once every N scans.
// RULE_17: Timeout from rate; set error, retry.
// RULE_18: Lowest identifier wins arbitration.
// RULE_19: At most 64 nodes, unique addresses.
// RULE_20: Bit rate 125, 250 or 500 kbit/s.
// RULE_21: Strobe answered by all; polls individually.
// RULE_22: Cyclic and change slaves send unprompted.
`timescale 1ns/10ps
`default_nettype none
module fss_scan_scheduler (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Scanner configuration
   input wire logic scan_enable,
   input wire logic [fss_pkg::INTV_W-1:0] scan_interval,
   input wire logic [1:0] rate_sel,
   input wire fss_pkg::fss_dev_cfg_t [fss_pkg::NUM_DEV-1:0] dev_cfg,
   // Host fast image
   input wire logic host_scan,
   input wire fss_pkg::fss_img_t hd_out,
   output var fss_pkg::fss_img_t hd_in_ff,
   // Host block transfer
   input wire logic bt_valid,
   input wire fss_pkg::fss_bt_req_t bt_req,
   output logic bt_ack_ff,
   output logic bt_err_ff,
   output logic [15:0] bt_rdata_ff,
   // Network link
   output logic tx_valid_ff,
   output var fss_pkg::fss_msg_t tx_msg_ff,
   input wire logic tx_ready,
   input wire logic rx_valid,
   input wire fss_pkg::fss_msg_t rx_msg,
   // Status
   output logic [1:0] link_rate_ff,
   output logic scan_busy_ff,
   output logic overrun_ff,
   output logic [fss_pkg::NUM_DEV-1:0] dev_conn,
   output logic [fss_pkg::NUM_DEV-1:0] dev_err
);
   localparam int N = fss_pkg::NUM_DEV;
   localparam int NW = fss_pkg::NODE_W;

   fss_pkg::fss_state_t state_ff;
   fss_pkg::fss_img_t stage_ff, pub_ff, out_img_ff;
   logic [15:0] bt_mem [0:fss_pkg::BT_MEM_WORDS-1];
   logic [fss_pkg::INTV_W-1:0] intv_cnt_ff;
   logic [fss_pkg::RETRY_W-1:0] scan_cnt_ff;
   logic [N-1:0] send_pend_ff, poll_due, pend, io_rsp, id_rsp, map_ack, nxt_send_pend;
   logic [NW-1:0] send_idx, map_idx, last_node_ff;
   logic send_any, map_any, intv_done, scan_start, tx_take, bt_ok, any_strobe;
   logic [15:0] rx_hold [0:N-1];

   function automatic logic [15:0] img_word(fss_pkg::fss_img_t img, logic [5:0] sel);
      if (sel == fss_pkg::SEL_DISC_LO) return img.disc[15:0];
      if (sel == fss_pkg::SEL_DISC_HI) return img.disc[31:16];
      if (sel < 6'(fss_pkg::HD_POINTS)) return img.words[sel[4:0]];
      return 16'h0000;
   endfunction

   function automatic fss_pkg::fss_img_t img_put(fss_pkg::fss_img_t img, logic [5:0] sel, logic [15:0] d);
      fss_pkg::fss_img_t r;
      r = img;
      if (sel == fss_pkg::SEL_DISC_LO) r.disc[15:0] = d;
      else if (sel == fss_pkg::SEL_DISC_HI) r.disc[31:16] = d;
      else if (sel < 6'(fss_pkg::HD_POINTS)) r.words[sel[4:0]] = d;
      return r;
   endfunction

   // Per-device trackers; node number is the address, so addresses are unique
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_dev
         assign io_rsp[g] = rx_valid && (rx_msg.kind == fss_pkg::MSG_IO) && (rx_msg.node == NW'(g)); // RULE_22
         assign id_rsp[g] = rx_valid && (rx_msg.kind == fss_pkg::MSG_IDREQ) && (rx_msg.node == NW'(g)); // RULE_19
         assign nxt_send_pend[g] = dev_cfg[g].active &&
            (dev_conn[g] ? (dev_cfg[g].poll && poll_due[g]) : (scan_cnt_ff == 3'h1)); // RULE_10
         fss_dev_tracker u_trk (
            .clock(clock),
            .rst(rst),
            .cfg(dev_cfg[g]),
            .scan_start(scan_start),
            .id_rsp(id_rsp[g]),
            .io_rsp(io_rsp[g]),
            .rsp_data(rx_msg.data),
            .map_ack(map_ack[g]),
            .poll_due_ff(poll_due[g]),
            .conn_ff(dev_conn[g]),
            .err_ff(dev_err[g]),
            .pend_ff(pend[g]),
            .data_ff()
         );
      end
   endgenerate

   // Lowest node first keeps our own frames in arbitration order
   fss_low_pick #(.W(N), .IW(NW)) u_send_pick (
      .req(send_pend_ff),
      .any(send_any),
      .idx(send_idx)
   ); // RULE_18

   fss_low_pick #(.W(N), .IW(NW)) u_map_pick (
      .req(pend & dev_conn),
      .any(map_any),
      .idx(map_idx)
   );

   assign map_ack = (state_ff == fss_pkg::S_MAP && map_any) ? (N'(1) << map_idx) : '0;
   assign intv_done = ({1'b0, intv_cnt_ff} + 25'h0000001) >= {1'b0, scan_interval};
   assign scan_start = scan_enable && ((state_ff == fss_pkg::S_OFF) ||
                       (state_ff == fss_pkg::S_WAIT && intv_done)); // RULE_11
   assign tx_take = tx_valid_ff && tx_ready;
   assign any_strobe = |(dev_conn & {N{1'b1}} & nxt_strobe_mask());
   assign bt_ok = bt_req.word < 6'(fss_pkg::BT_WORDS); // RULE_07

   function automatic logic [N-1:0] nxt_strobe_mask();
      logic [N-1:0] m;
      m = '0;
      for (int i = 0; i < N; i++) m[i] = dev_cfg[i].active && dev_cfg[i].strobe;
      return m;
   endfunction

   // Scan sequencer
   always_ff @(posedge clock) begin
      if (rst) begin
         state_ff <= fss_pkg::S_OFF;
      end else begin
         unique case (state_ff)
            fss_pkg::S_OFF, fss_pkg::S_WAIT: begin
               if (scan_start) state_ff <= fss_pkg::S_STROBE;
               else if (!scan_enable) state_ff <= fss_pkg::S_OFF; // RULE_14
            end
            fss_pkg::S_STROBE: state_ff <= fss_pkg::S_SEND;
            fss_pkg::S_SEND: begin
               if (!send_any && !tx_valid_ff) state_ff <= fss_pkg::S_MAP; // RULE_13
            end
            fss_pkg::S_MAP: begin
               if (!map_any) state_ff <= fss_pkg::S_COMMIT; // RULE_15
            end
            fss_pkg::S_COMMIT: state_ff <= fss_pkg::S_WAIT;
         endcase
      end
   end

   // Interval timer measured start to start; the retry counter paces reconnects
   always_ff @(posedge clock) begin
      if (rst) begin
         intv_cnt_ff <= '0;
         scan_cnt_ff <= '0;
      end else if (scan_start) begin
         intv_cnt_ff <= '0; // RULE_11
         scan_cnt_ff <= scan_cnt_ff + 1'b1; // RULE_17
      end else if (!intv_done) begin
         intv_cnt_ff <= intv_cnt_ff + 1'b1;
      end
   end

   // Overrun sticks until scanning is switched off
   always_ff @(posedge clock) begin
      if (rst) begin
         overrun_ff <= 1'b0;
         scan_busy_ff <= 1'b0;
      end else begin
         scan_busy_ff <= (state_ff != fss_pkg::S_OFF) && (state_ff != fss_pkg::S_WAIT);
         if (intv_done && state_ff inside {fss_pkg::S_STROBE, fss_pkg::S_SEND, fss_pkg::S_MAP, fss_pkg::S_COMMIT})
            overrun_ff <= 1'b1; // RULE_15
         else if (!scan_enable)
            overrun_ff <= 1'b0;
      end
   end

   // Transmit side: one strobe if a connected device takes strobes, then polls and identity requests
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_valid_ff <= 1'b0;
         tx_msg_ff <= '0;
         send_pend_ff <= '0;
         last_node_ff <= '0;
      end else begin
         if (tx_take) tx_valid_ff <= 1'b0;
         if (state_ff == fss_pkg::S_STROBE) begin
            send_pend_ff <= nxt_send_pend; // RULE_12
            last_node_ff <= '0;
            if (any_strobe) begin
               tx_valid_ff <= 1'b1; // RULE_21
               tx_msg_ff <= '{kind: fss_pkg::MSG_STROBE, node: '0, data: 16'h0000};
            end
         end else if (state_ff == fss_pkg::S_SEND && send_any && (!tx_valid_ff || tx_take)) begin
            tx_valid_ff <= 1'b1;
            send_pend_ff[send_idx] <= 1'b0;
            last_node_ff <= send_idx;
            tx_msg_ff.node <= send_idx; // RULE_21
            tx_msg_ff.kind <= dev_conn[send_idx] ? fss_pkg::MSG_POLL : fss_pkg::MSG_IDREQ;
            tx_msg_ff.data <= img_word(out_img_ff, dev_cfg[send_idx].map_sel); // RULE_09
         end
      end
   end

   // Staging image filled by mapping, published whole at commit
   always_ff @(posedge clock) begin
      if (rst) begin
         stage_ff <= '0;
         pub_ff <= '0;
      end else begin
         if (state_ff == fss_pkg::S_MAP && map_any)
            stage_ff <= img_put(stage_ff, dev_cfg[map_idx].map_sel, g_pick_data(map_idx)); // RULE_13
         if (state_ff == fss_pkg::S_COMMIT)
            pub_ff <= stage_ff; // RULE_05
      end
   end

   function automatic logic [15:0] g_pick_data(logic [NW-1:0] i);
      return rx_hold[i];
   endfunction

   // Shadow of buffered response words for the mapper
   always_ff @(posedge clock) begin
      if (rx_valid && rx_msg.kind == fss_pkg::MSG_IO && dev_conn[rx_msg.node])
         rx_hold[rx_msg.node] <= rx_msg.data; // RULE_12
   end

   // Host fast image: inputs from the input block, outputs into the output block
   always_ff @(posedge clock) begin
      if (rst) begin
         hd_in_ff <= '0;
         out_img_ff <= '0;
      end else if (host_scan) begin
         hd_in_ff <= pub_ff; // RULE_03
         out_img_ff <= hd_out; // RULE_04
      end
   end

   // Block transfer blocks, one answer per request, next cycle
   always_ff @(posedge clock) begin
      if (bt_valid && bt_ok && bt_req.write)
         bt_mem[{bt_req.blk, bt_req.word}] <= bt_req.wdata; // RULE_02
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         bt_ack_ff <= 1'b0;
         bt_err_ff <= 1'b0;
         bt_rdata_ff <= 16'h0000;
      end else begin
         bt_ack_ff <= bt_valid;
         bt_err_ff <= bt_valid && !bt_ok; // RULE_07
         bt_rdata_ff <= (bt_valid && bt_ok) ? bt_mem[{bt_req.blk, bt_req.word}] : 16'h0000; // RULE_01
      end
   end

   // Only the three documented rates; anything else falls back to the slowest
   always_ff @(posedge clock) begin
      if (rst) link_rate_ff <= fss_pkg::RATE_125K;
      else if (rate_sel inside {fss_pkg::RATE_125K, fss_pkg::RATE_250K, fss_pkg::RATE_500K})
         link_rate_ff <= rate_sel; // RULE_20
      else link_rate_ff <= fss_pkg::RATE_125K;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   host_image_a: assert property ($changed(hd_in_ff) |-> $past(host_scan)) // RULE_06
      else $error("fast input image changed outside a host scan");
   out_capture_a: assert property (host_scan |=> out_img_ff == $past(hd_out)) // RULE_04
      else $error("output image not captured on host scan");
   publish_whole_a: assert property ($changed(pub_ff) |-> $past(state_ff) == fss_pkg::S_COMMIT) // RULE_05
      else $error("published image changed outside commit");
   map_after_send_a: assert property (state_ff == fss_pkg::S_MAP |-> !tx_valid_ff && send_pend_ff == '0) // RULE_13
      else $error("mapping while messages still unsent");
   idle_wait_a: assert property (state_ff == fss_pkg::S_WAIT && !intv_done |=> !tx_valid_ff) // RULE_14
      else $error("transmit while idle before interval");
   start_interval_a: assert property (scan_start && state_ff == fss_pkg::S_WAIT |-> intv_done) // RULE_11
      else $error("scan started before interval end");
   overrun_flag_a: assert property (intv_done && state_ff == fss_pkg::S_SEND |=> overrun_ff) // RULE_15
      else $error("late scan not flagged");
   poll_needs_conn_a: assert property (tx_valid_ff && tx_msg_ff.kind == fss_pkg::MSG_POLL |-> dev_conn[tx_msg_ff.node]) // RULE_10
      else $error("poll sent to unverified device");
   low_first_a: assert property (state_ff == fss_pkg::S_SEND && send_any && tx_valid_ff && tx_msg_ff.kind != fss_pkg::MSG_STROBE |-> send_idx > tx_msg_ff.node) // RULE_18
      else $error("send order not lowest node first");
   rate_legal_a: assert property (link_rate_ff != 2'h3) // RULE_20
      else $error("illegal link bit rate");
   bt_answer_a: assert property (bt_valid && bt_req.word >= 6'h3C |=> bt_ack_ff && bt_err_ff) // RULE_07
      else $error("out of range block word not refused");

   overrun_c: cover property (state_ff == fss_pkg::S_MAP ##1 overrun_ff);
   poll_sent_c: cover property (tx_take && tx_msg_ff.kind == fss_pkg::MSG_POLL);
   commit_c: cover property (state_ff == fss_pkg::S_COMMIT ##[1:20] host_scan);
   bt_write_c: cover property (bt_valid && bt_req.write && bt_ok);
endmodule // fss_scan_scheduler
`default_nettype wire

// ### test/fss_net_model.sv
/*
 Behavioural slave network for the scan scheduler: takes frames with
 periodic stalls and queues strobe, poll and identity answers.
 Assumes a single clock shared with the scheduler.
*/
`timescale 1ns/10ps
`default_nettype none
module fss_net_model #(
   parameter int STROBE_NODE = 7
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Frames from the scanner
   input wire logic tx_valid,
   input wire fss_pkg::fss_msg_t tx_msg,
   output logic tx_ready,
   // Frames to the scanner
   output logic rx_valid,
   output var fss_pkg::fss_msg_t rx_msg,
   // Fault controls
   input wire logic mute_en,
   input wire logic [5:0] mute_node,
   input wire logic [5:0] bad_node
);
   fss_pkg::fss_msg_t q[$];
   logic [1:0] st_ff;
   logic [5:0] cyc_ff;

   always @(posedge clock) begin
      if (rst) begin
         st_ff <= 2'h0;
         cyc_ff <= 6'h01;
         tx_ready <= 1'b0;
         rx_valid <= 1'b0;
         rx_msg <= '1;
         q.delete();
      end else begin
         // Link busy one cycle in four
         st_ff <= st_ff + 2'h1;
         tx_ready <= (st_ff != 2'h3);
         cyc_ff <= cyc_ff + 6'h01;
         // Strobe node also reports on its own timer, unprompted
         if (cyc_ff == 6'h00)
            q.push_back('{fss_pkg::MSG_IO, 6'(STROBE_NODE), 16'hA500 + 16'(STROBE_NODE)});
         if (tx_valid && tx_ready && !(mute_en && tx_msg.node == mute_node)) begin
            case (tx_msg.kind)
               fss_pkg::MSG_IDREQ:
                  q.push_back('{fss_pkg::MSG_IDREQ, tx_msg.node,
                               (tx_msg.node == bad_node) ? 16'hDEAD : 16'h0100 + 16'(tx_msg.node)});
               fss_pkg::MSG_POLL:
                  q.push_back('{fss_pkg::MSG_IO, tx_msg.node, 16'hA500 + 16'(tx_msg.node)});
               fss_pkg::MSG_STROBE:
                  q.push_back('{fss_pkg::MSG_IO, 6'(STROBE_NODE), 16'hA500 + 16'(STROBE_NODE)});
               default: ;
            endcase
         end
         rx_valid <= 1'b0;
         // Idle data inverted so a stale frame never looks valid
         rx_msg <= ~rx_msg;
         if (st_ff[0] && q.size() > 0) begin
            rx_valid <= 1'b1;
            rx_msg <= q.pop_front();
         end
      end
   end
endmodule // fss_net_model
`default_nettype wire

// ### test/tb_top.sv
/*
 Self-checking bench of the scan scheduler with a slave network model.
 Assumes the package, the design and fss_net_model compile first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clock, rst, scan_enable, host_scan, bt_valid, mute_en, busy_q;
   logic [fss_pkg::INTV_W-1:0] scan_interval;
   logic [1:0] rate_sel, link_rate_ff;
   fss_pkg::fss_dev_cfg_t [fss_pkg::NUM_DEV-1:0] dev_cfg;
   fss_pkg::fss_img_t hd_out, hd_in_ff;
   fss_pkg::fss_bt_req_t bt_req;
   logic bt_ack_ff, bt_err_ff, tx_valid_ff, tx_ready, rx_valid, overrun_ff, scan_busy_ff;
   logic [15:0] bt_rdata_ff;
   fss_pkg::fss_msg_t tx_msg_ff, rx_msg;
   logic [63:0] dev_conn, dev_err;
   int n_mismatch, check_count, n_poll3, n_scan, cyc, last_start, period;

   fss_scan_scheduler i_fss_scan_scheduler (.clock, .rst, .scan_enable, .scan_interval, .rate_sel,
      .dev_cfg, .host_scan, .hd_out, .hd_in_ff, .bt_valid, .bt_req, .bt_ack_ff, .bt_err_ff,
      .bt_rdata_ff, .tx_valid_ff, .tx_msg_ff, .tx_ready, .rx_valid, .rx_msg, .link_rate_ff,
      .scan_busy_ff, .overrun_ff, .dev_conn, .dev_err);
   fss_net_model i_fss_net_model (.clock, .rst, .tx_valid(tx_valid_ff), .tx_msg(tx_msg_ff),
      .tx_ready, .rx_valid, .rx_msg, .mute_en, .mute_node(6'h03), .bad_node(6'h09));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Scan starts seen as rises of busy, frames counted at the take
   always @(posedge clock) begin
      cyc++;
      if (scan_busy_ff && !busy_q) begin
         n_scan++;
         period = cyc - last_start;
         last_start = cyc;
      end
      busy_q = scan_busy_ff;
      if (tx_valid_ff && tx_ready) begin
         if (tx_msg_ff.kind == fss_pkg::MSG_STROBE) chk(tx_msg_ff.node, 6'h00);
         chk(tx_msg_ff.kind == fss_pkg::MSG_POLL && tx_msg_ff.node == 6'h09, 1'b0);
         if (tx_msg_ff.kind == fss_pkg::MSG_POLL && tx_msg_ff.node == 6'h03) n_poll3++;
      end
   end

   task automatic wait_scans(input int n);
      int s;
      repeat (n) begin
         s = n_scan;
         for (int i = 0; i < 2000 && n_scan == s; i++) @(posedge clock);
      end
      #1;
   endtask

   task automatic bt(input logic wr, input logic [2:0] blk, input logic [5:0] word,
                     input logic [15:0] wd, input logic err, input logic [15:0] rd);
      @(posedge clock);
      bt_valid <= 1'b1;
      bt_req <= '{wr, blk, word, wd};
      @(posedge clock);
      bt_valid <= 1'b0;
      #1;
      chk(bt_ack_ff, 1'b1);
      chk(bt_err_ff, err);
      if (!wr || err) chk(bt_rdata_ff, rd);
      @(posedge clock);
      #1;
      chk(bt_ack_ff, 1'b0);
   endtask

   task automatic t_rate;
      for (int r = 0; r < 4; r++) begin
         @(posedge clock);
         rate_sel <= 2'(r);
         repeat (3) @(posedge clock);
         #1;
         chk(link_rate_ff, (r == 3) ? 2'h0 : 2'(r));
      end
   endtask

   task automatic t_bt;
      bt(1'b1, 3'h0, 6'h00, 16'h1111, 1'b0, 16'h0000);
      bt(1'b1, 3'h7, 6'h3B, 16'hBEEF, 1'b0, 16'h0000);
      bt(1'b0, 3'h7, 6'h3B, 16'h0000, 1'b0, 16'hBEEF);
      bt(1'b0, 3'h0, 6'h00, 16'h0000, 1'b0, 16'h1111);
      bt(1'b1, 3'h7, 6'h3C, 16'h5555, 1'b1, 16'h0000);
      bt(1'b0, 3'h7, 6'h3C, 16'h0000, 1'b1, 16'h0000);
   endtask

   task automatic t_scan;
      int p;
      @(posedge clock);
      scan_enable <= 1'b1;
      wait_scans(3);
      chk({dev_conn[3], dev_conn[7], dev_conn[9]}, 3'b110);
      chk(dev_err[9], 1'b1);
      wait_scans(2);
      chk(period, 200);
      repeat (150) @(posedge clock);
      #1;
      chk(scan_busy_ff, 1'b0);
      chk(overrun_ff, 1'b0);
      @(posedge clock);
      host_scan <= 1'b1;
      @(posedge clock);
      host_scan <= 1'b0;
      #1;
      chk(hd_in_ff.words[5], 16'hA503);
      chk(hd_in_ff.disc[15:0], 16'hA507);
      p = n_poll3;
      wait_scans(8);
      // Let the eighth scan's polls go out before counting
      repeat (50) @(posedge clock);
      chk(n_poll3 - p, 4);
   endtask

   task automatic t_timeout;
      @(posedge clock);
      mute_en <= 1'b1;
      for (int i = 0; i < 12 && !dev_err[3]; i++) wait_scans(1);
      chk({dev_err[3], dev_conn[3]}, 2'b10);
      @(posedge clock);
      mute_en <= 1'b0;
      for (int i = 0; i < 20 && !dev_conn[3]; i++) wait_scans(1);
      chk({dev_err[3], dev_conn[3]}, 2'b01);
   endtask

   task automatic t_overrun;
      @(posedge clock);
      scan_interval <= 24'h000006;
      for (int i = 0; i < 300 && !overrun_ff; i++) @(posedge clock);
      #1;
      chk(overrun_ff, 1'b1);
      @(posedge clock);
      scan_enable <= 1'b0;
      for (int i = 0; i < 600 && overrun_ff; i++) @(posedge clock);
      #1;
      chk(overrun_ff, 1'b0);
   endtask

   initial begin
      rst = 1'b1;
      scan_enable = 1'b0;
      scan_interval = 24'd200;
      rate_sel = 2'h0;
      dev_cfg = '0;
      dev_cfg[3] = '{1'b1, 1'b0, 1'b1, 1'b0, 4'h2, 8'h00, 6'h05, 16'h0103};
      dev_cfg[7] = '{1'b1, 1'b1, 1'b0, 1'b0, 4'h1, 8'h00, 6'h20, 16'h0107};
      dev_cfg[9] = '{1'b1, 1'b0, 1'b1, 1'b0, 4'h1, 8'h00, 6'h06, 16'h0109};
      host_scan = 1'b0;
      hd_out = '0;
      bt_valid = 1'b0;
      bt_req = '0;
      mute_en = 1'b0;
      busy_q = 1'b0;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      chk(link_rate_ff, 2'h0);
      chk(dev_conn, 64'h0);
      chk({tx_valid_ff, overrun_ff}, 2'b00);
      t_rate();
      t_bt();
      t_scan();
      t_timeout();
      t_overrun();
      close_out();
   end

   // Whole run needs about 5100 cycles
   initial begin
      repeat (60000) @(posedge clock);
      n_mismatch++;
      close_out();
   end
endmodule // tb_top
`default_nettype wire
